// ==== hw/rss_pkg.sv ====
`default_nettype none

package rss_pkg;

  // ----------------------------------------------------------------------
  // register port request, one cycle wide
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic [7:0] addr;   // byte address
    logic [15:0] wdata; // write data
    logic wr;           // write strobe
    logic rd;           // read strobe
  } rss_bus_req_type;

  // cpu release state
  typedef enum logic [0:0] {
    ST_HOLD,
    ST_RUN
  } rss_state_type;

  // source of the most recent reset
  typedef enum logic [2:0] {
    SRC_POWER,
    SRC_PIN,
    SRC_WDT,
    SRC_MON1,
    SRC_MON2,
    SRC_SOFT
  } rss_src_type;

endpackage : rss_pkg

`default_nettype wire

// ==== hw/rss_regs.svh ====
`ifndef RSS_REGS_SVH
`define RSS_REGS_SVH

// ----------------------------------------------------------------------
// register offsets (byte addresses, one word each)
// ----------------------------------------------------------------------
`define RSS_OFS_STATUS0 8'h00
`define RSS_OFS_STATUS1 8'h04
`define RSS_OFS_STATUS2 8'h08
`define RSS_OFS_SOFT_KEY 8'h0C
`define RSS_OFS_MON1_CTL 8'h10
`define RSS_OFS_MON2_CTL 8'h14
`define RSS_OFS_LEVEL 8'h18
`define RSS_OFS_WDT_CTL 8'h1C
`define RSS_OFS_PROTECT 8'h20
`define RSS_OFS_SEQ 8'h24

// ----------------------------------------------------------------------
// field positions
// ----------------------------------------------------------------------
`define RSS_BIT_POR 0
`define RSS_BIT_MON1 2
`define RSS_BIT_MON2 3
`define RSS_BIT_COLD_WARM_FLAG 0
`define RSS_BIT_WDT 0
`define RSS_BIT_SOFT 2
`define RSS_BIT_MON_EN 0
`define RSS_BIT_MON_MODE 1
`define RSS_BIT_MON_REL 2
`define RSS_BIT_WDT_EN 0
`define RSS_BIT_PROT1 1
`define RSS_BIT_OW_STOP 1
`define RSS_BIT_OW_RSTSEL 12

// ----------------------------------------------------------------------
// reset values and key
// ----------------------------------------------------------------------
`define RSS_MON_CTL_RST 3'h0
`define RSS_LVL1_RST 4'h0
`define RSS_LVL2_RST 2'h0
`define RSS_SOFT_KEY 16'hA501

// ----------------------------------------------------------------------
// timing in ns, rounded up to whole clock cycles
// ----------------------------------------------------------------------
`define RSS_CLK_NS 40
`define RSS_PIN_WAIT_NS 40000
`define RSS_POR_NS 2000000
`define RSS_MON1_NS 100000
`define RSS_MON2_NS 100000
`define RSS_INT_RST_NS 20000
`define RSS_CYC(t) (((t) + `RSS_CLK_NS - 1) / `RSS_CLK_NS)
`define RSS_PIN_WAIT_CYC `RSS_CYC(`RSS_PIN_WAIT_NS)
`define RSS_POR_CYC `RSS_CYC(`RSS_POR_NS)
`define RSS_MON1_CYC `RSS_CYC(`RSS_MON1_NS)
`define RSS_MON2_CYC `RSS_CYC(`RSS_MON2_NS)
`define RSS_INT_RST_CYC `RSS_CYC(`RSS_INT_RST_NS)

`endif

// ==== hw/rss_sync.sv ====
`default_nettype none

// ----------------------------------------------------------------------
// two-flop synchroniser for pin and analog detector levels
// ----------------------------------------------------------------------
module rss_sync #(
  parameter int WIDTH = 4
) (
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] meta; // first stage, read only by the second

  // reset low: pin and power-on read as active at start
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      meta <= '0;
      sync_out <= '0;
    end else begin
      meta <= async_in;
      sync_out <= meta;
    end
  end

endmodule : rss_sync

`default_nettype wire

// ==== hw/rss_timer.sv ====
`default_nettype none

// ----------------------------------------------------------------------
// release timer: load holds it at full length, then it counts down
// ----------------------------------------------------------------------
module rss_timer #(
  parameter logic [15:0] LEN = 16'h0001,
  parameter logic START_BUSY = 1'b0
) (
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic load,
  output logic busy
);

  logic [15:0] cnt; // cycles left before this source lets go

  // a held load reloads, so the wait starts when load drops
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      cnt <= START_BUSY ? LEN : 16'h0000;
    end else if (load) begin
      cnt <= LEN;
    end else if (cnt != 16'h0000) begin
      cnt <= cnt - 16'h0001;
    end
  end

  assign busy = (cnt != 16'h0000);

endmodule : rss_timer

`default_nettype wire

// ==== hw/rss_top.sv ====
// The implementer's own choices: the register addresses and the address-and-strobe port.
`include "rss_regs.svh"
`default_nettype none

// What this block does
// RULE1: pin low aborts everything and holds reset
// RULE2: pin high then pin wait before release
// RULE3: power-on holds until threshold plus period
// RULE4: power-on reset sets power-on detect flag
// RULE5: pin reset clears power-on detect flag
// RULE6: enabled monitor-1 low sets flag, resets
// RULE7: enabled monitor-2 low sets flag, resets
// RULE8: release select 0: recovery then delay
// RULE9: release select 1: delay from detection only
// RULE10: monitor-2 has the same release select
// RULE11: software sets both detection levels
// RULE12: watchdog reset enable from control and option
// RULE13: enabled watchdog underflow or refresh error resets
// RULE14: watchdog reset holds internal reset time
// RULE15: only the key value raises software reset
// RULE16: software reset holds internal reset time
// RULE17: only power-on clears cold/warm flag
// RULE18: write 1 sets cold/warm, 0 ignored
// RULE19: detect flags readable in two status registers
// RULE20: flag clears by 0 after read 1
// RULE21: software reset register reads all zeros
// RULE22: key writes ignored while protection active
// RULE23: cpu released only when every timer ended
module rss_top import rss_pkg::*; #(
  parameter int POR_CYCLES = `RSS_POR_CYC
) (
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic ext_reset_pin_n,
  input wire logic vcc_above_por,
  input wire logic vcc_below_level1,
  input wire logic vcc_below_level2,
  input wire logic [31:0] option_word0,
  input wire logic wdt_underflow,
  input wire logic wdt_refresh_error,
  input wire rss_bus_req_type bus_req,
  output logic [15:0] rd_data,
  output logic cpu_reset_n,
  output logic [3:0] level1_select,
  output logic [1:0] level2_select
);

  // ----------------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------------

  // write strobe aimed at one register
  function automatic logic wr_to(input rss_bus_req_type r, input logic [7:0] a);
    return r.wr & (r.addr == a);
  endfunction : wr_to

  // read strobe aimed at one register
  function automatic logic rd_to(input rss_bus_req_type r, input logic [7:0] a);
    return r.rd & (r.addr == a);
  endfunction : rd_to

  // software clear: a 0 written to a bit that was read as 1
  function automatic logic sw_clr(input logic armed, input logic hit, input logic wbit);
    return armed & hit & ~wbit;
  endfunction : sw_clr

  // ----------------------------------------------------------------------
  // synchronised inputs
  // ----------------------------------------------------------------------
  logic [3:0] pins_s; // pin, por ok, below level 1, below level 2
  logic mon1_low_d; // previous monitor-1 level, for the edge
  logic mon2_low_d; // previous monitor-2 level, for the edge

  rss_sync #(
    .WIDTH(4)
  ) u_sync (
    .sys_clk(sys_clk),
    .rstn(rstn),
    .async_in({ext_reset_pin_n, vcc_above_por, vcc_below_level1, vcc_below_level2}),
    .sync_out(pins_s)
  );

  logic pin_low; // pin driven low
  logic por_low; // supply below power-on threshold
  logic mon1_low; // supply at or below level 1
  logic mon2_low; // supply at or below level 2

  assign pin_low = ~pins_s[3];
  assign por_low = ~pins_s[2];
  assign mon1_low = pins_s[1];
  assign mon2_low = pins_s[0];

  // previous monitor levels, from the second stage
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      mon1_low_d <= 1'b0;
      mon2_low_d <= 1'b0;
    end else begin
      mon1_low_d <= mon1_low;
      mon2_low_d <= mon2_low;
    end
  end

  // ----------------------------------------------------------------------
  // software registers
  // ----------------------------------------------------------------------
  logic flag_por; // power-on detect
  logic flag_mon1; // monitor-1 reset detect
  logic flag_mon2; // monitor-2 reset detect
  logic flag_wdt; // watchdog reset detect
  logic flag_soft; // software reset detect
  logic cold_warm_flag; // 0 cold start, 1 warm start
  logic [4:0] armed; // flag read as 1: por, mon1, mon2, wdt, soft
  logic [2:0] mon1_control0; // enable, mode, release select
  logic [2:0] mon2_control0; // enable, mode, release select
  logic wdt_reset_ctl; // watchdog reset enable when not auto-started
  logic protect_write_enable1; // unlocks the software reset key
  rss_state_type state; // cpu held or running
  rss_state_type next_state;
  rss_src_type last_src; // most recent reset source

  // ----------------------------------------------------------------------
  // reset events
  // ----------------------------------------------------------------------
  logic deep_clear; // power-on or pin: widest initialisation
  logic mon1_event; // monitor-1 reset raised this cycle
  logic mon2_event; // monitor-2 reset raised this cycle
  logic wdt_enable; // watchdog reset output allowed
  logic wdt_event; // watchdog reset raised this cycle
  logic soft_event; // software reset raised this cycle
  logic any_event; // any source starts a reset this cycle

  assign deep_clear = por_low | pin_low; // RULE1

  // only a falling supply is a detection: a level that stays low under
  // delay-only release does not retrigger after its timer runs out
  assign mon1_event = mon1_control0[`RSS_BIT_MON_EN] & mon1_control0[`RSS_BIT_MON_MODE]
                    & mon1_low & ~mon1_low_d; // RULE6
  assign mon2_event = mon2_control0[`RSS_BIT_MON_EN] & mon2_control0[`RSS_BIT_MON_MODE]
                    & mon2_low & ~mon2_low_d; // RULE7

  // auto-start takes the option word's choice, else the control bit
  assign wdt_enable = option_word0[`RSS_BIT_OW_STOP] ? wdt_reset_ctl
                    : option_word0[`RSS_BIT_OW_RSTSEL]; // RULE12
  assign wdt_event = wdt_enable & (wdt_underflow | wdt_refresh_error); // RULE13

  assign soft_event = wr_to(bus_req, `RSS_OFS_SOFT_KEY) & protect_write_enable1 // RULE22
                    & (bus_req.wdata == `RSS_SOFT_KEY); // RULE15

  assign any_event = deep_clear | mon1_event | mon2_event | wdt_event | soft_event;

  // ----------------------------------------------------------------------
  // release timers, one per timing
  // ----------------------------------------------------------------------
  logic pin_busy; // pin low or pin wait running
  logic por_busy; // supply low or power-on period running
  logic mon1_busy; // monitor-1 reset time running
  logic mon2_busy; // monitor-2 reset time running
  logic int_busy; // internal reset time running
  logic mon1_load; // reload for monitor-1
  logic mon2_load; // reload for monitor-2

  // release select 0 keeps reloading while the supply stays low
  assign mon1_load = mon1_event
                   | (mon1_busy & mon1_low & ~mon1_control0[`RSS_BIT_MON_REL]); // RULE8 RULE9
  assign mon2_load = mon2_event
                   | (mon2_busy & mon2_low & ~mon2_control0[`RSS_BIT_MON_REL]); // RULE10

  rss_timer #(
    .LEN(16'(`RSS_PIN_WAIT_CYC)),
    .START_BUSY(1'b1)
  ) u_pin_timer (
    .sys_clk(sys_clk),
    .rstn(rstn),
    .load(pin_low), // RULE2
    .busy(pin_busy)
  );

  rss_timer #(
    .LEN(16'(POR_CYCLES)),
    .START_BUSY(1'b1)
  ) u_por_timer (
    .sys_clk(sys_clk),
    .rstn(rstn),
    .load(por_low), // RULE3
    .busy(por_busy)
  );

  rss_timer #(
    .LEN(16'(`RSS_MON1_CYC))
  ) u_mon1_timer (
    .sys_clk(sys_clk),
    .rstn(rstn),
    .load(mon1_load),
    .busy(mon1_busy)
  );

  rss_timer #(
    .LEN(16'(`RSS_MON2_CYC))
  ) u_mon2_timer (
    .sys_clk(sys_clk),
    .rstn(rstn),
    .load(mon2_load),
    .busy(mon2_busy)
  );

  // watchdog and software resets share the internal reset time
  rss_timer #(
    .LEN(16'(`RSS_INT_RST_CYC))
  ) u_int_timer (
    .sys_clk(sys_clk),
    .rstn(rstn),
    .load(wdt_event | soft_event), // RULE14 RULE16
    .busy(int_busy)
  );

  // ----------------------------------------------------------------------
  // detect flags: a hardware set always beats a clear
  // ----------------------------------------------------------------------
  logic wr_s0; // write to status register 0
  logic wr_s2; // write to status register 2

  assign wr_s0 = wr_to(bus_req, `RSS_OFS_STATUS0);
  assign wr_s2 = wr_to(bus_req, `RSS_OFS_STATUS2);

  // status 0 flags; heavier resets wipe lighter flags
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      flag_por <= 1'b1; // RULE4
      flag_mon1 <= 1'b0;
      flag_mon2 <= 1'b0;
    end else begin
      flag_por <= por_low // RULE4
                | (flag_por & ~pin_low // RULE5
                   & ~sw_clr(armed[0], wr_s0, bus_req.wdata[`RSS_BIT_POR])); // RULE20
      flag_mon1 <= mon1_event // RULE6
                 | (flag_mon1 & ~deep_clear & ~wdt_event
                    & ~sw_clr(armed[1], wr_s0, bus_req.wdata[`RSS_BIT_MON1])); // RULE20
      flag_mon2 <= mon2_event // RULE7
                 | (flag_mon2 & ~deep_clear & ~wdt_event & ~mon1_event
                    & ~sw_clr(armed[2], wr_s0, bus_req.wdata[`RSS_BIT_MON2])); // RULE20
    end
  end

  // status register 2 flags
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      flag_wdt <= 1'b0;
      flag_soft <= 1'b0;
    end else begin
      flag_wdt <= wdt_event
                | (flag_wdt & ~deep_clear
                   & ~sw_clr(armed[3], wr_s2, bus_req.wdata[`RSS_BIT_WDT])); // RULE20
      flag_soft <= soft_event
                 | (flag_soft & ~deep_clear & ~wdt_event & ~mon1_event & ~mon2_event
                    & ~sw_clr(armed[4], wr_s2, bus_req.wdata[`RSS_BIT_SOFT])); // RULE20
    end
  end

  // read-as-1 memory: set by a read, spent by a write
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      armed <= 5'h00;
    end else begin
      if (rd_to(bus_req, `RSS_OFS_STATUS0)) begin
        armed[2:0] <= {flag_mon2, flag_mon1, flag_por}; // RULE20
      end else if (wr_s0) begin
        armed[2:0] <= 3'h0;
      end
      if (rd_to(bus_req, `RSS_OFS_STATUS2)) begin
        armed[4:3] <= {flag_soft, flag_wdt}; // RULE20
      end else if (wr_s2) begin
        armed[4:3] <= 2'h0;
      end
    end
  end

  // cold/warm flag: only a power-on returns it to cold
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      cold_warm_flag <= 1'b0; // RULE17
    end else if (por_low) begin
      cold_warm_flag <= 1'b0; // RULE17
    end else if (wr_to(bus_req, `RSS_OFS_STATUS1) & bus_req.wdata[`RSS_BIT_COLD_WARM_FLAG]) begin
      cold_warm_flag <= 1'b1; // RULE18
    end
  end

  // ----------------------------------------------------------------------
  // control registers
  // ----------------------------------------------------------------------

  // monitor controls and levels; same clears as their flags
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      mon1_control0 <= `RSS_MON_CTL_RST;
      mon2_control0 <= `RSS_MON_CTL_RST;
      level1_select <= `RSS_LVL1_RST;
      level2_select <= `RSS_LVL2_RST;
    end else begin
      if (deep_clear | wdt_event) begin
        mon1_control0 <= `RSS_MON_CTL_RST;
        level1_select <= `RSS_LVL1_RST;
      end else begin
        if (wr_to(bus_req, `RSS_OFS_MON1_CTL)) begin
          mon1_control0 <= bus_req.wdata[2:0];
        end
        if (wr_to(bus_req, `RSS_OFS_LEVEL)) begin
          level1_select <= bus_req.wdata[3:0]; // RULE11
        end
      end
      if (deep_clear | wdt_event | mon1_event) begin
        mon2_control0 <= `RSS_MON_CTL_RST;
        level2_select <= `RSS_LVL2_RST;
      end else begin
        if (wr_to(bus_req, `RSS_OFS_MON2_CTL)) begin
          mon2_control0 <= bus_req.wdata[2:0]; // RULE10
        end
        if (wr_to(bus_req, `RSS_OFS_LEVEL)) begin
          level2_select <= bus_req.wdata[5:4]; // RULE11
        end
      end
    end
  end

  // watchdog control survives all but power-on and pin
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      wdt_reset_ctl <= 1'b0;
    end else if (deep_clear) begin
      wdt_reset_ctl <= 1'b0;
    end else if (wr_to(bus_req, `RSS_OFS_WDT_CTL)) begin
      wdt_reset_ctl <= bus_req.wdata[`RSS_BIT_WDT_EN]; // RULE12
    end
  end

  // protection bit falls back to locked on any reset
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      protect_write_enable1 <= 1'b0;
    end else if (any_event) begin
      protect_write_enable1 <= 1'b0;
    end else if (wr_to(bus_req, `RSS_OFS_PROTECT)) begin
      protect_write_enable1 <= bus_req.wdata[`RSS_BIT_PROT1];
    end
  end

  // ----------------------------------------------------------------------
  // cpu release sequencing
  // ----------------------------------------------------------------------
  logic any_busy; // some source still holds reset

  assign any_busy = pin_busy | por_busy | mon1_busy | mon2_busy | int_busy;

  // an event in the same cycle counts, so a timer's one-cycle load
  // latency can never open a release gap
  always_comb begin
    next_state = state;
    case (state)
      ST_HOLD: begin
        if (!any_busy && !any_event) begin
          next_state = ST_RUN; // RULE23
        end
      end
      ST_RUN: begin
        if (any_busy || any_event) begin
          next_state = ST_HOLD; // RULE1
        end
      end
      default: begin
        next_state = ST_HOLD;
      end
    endcase
  end

  // state and its registered output copy
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      state <= ST_HOLD;
      cpu_reset_n <= 1'b0;
    end else begin
      state <= next_state;
      cpu_reset_n <= (next_state == ST_RUN); // RULE23
    end
  end

  // latest source, heaviest first
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      last_src <= SRC_POWER;
    end else if (por_low) begin
      last_src <= SRC_POWER;
    end else if (pin_low) begin
      last_src <= SRC_PIN;
    end else if (wdt_event) begin
      last_src <= SRC_WDT;
    end else if (mon1_event) begin
      last_src <= SRC_MON1;
    end else if (mon2_event) begin
      last_src <= SRC_MON2;
    end else if (soft_event) begin
      last_src <= SRC_SOFT;
    end
  end

  // ----------------------------------------------------------------------
  // read port: data the cycle after the strobe, else zero
  // ----------------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      rd_data <= 16'h0000;
    end else if (bus_req.rd) begin
      case (bus_req.addr)
        `RSS_OFS_STATUS0: rd_data <= {12'h000, flag_mon2, flag_mon1, 1'b0, flag_por}; // RULE19
        `RSS_OFS_STATUS1: rd_data <= {15'h0000, cold_warm_flag};
        `RSS_OFS_STATUS2: rd_data <= {13'h0000, flag_soft, 1'b0, flag_wdt}; // RULE19
        `RSS_OFS_SOFT_KEY: rd_data <= 16'h0000; // RULE21
        `RSS_OFS_MON1_CTL: rd_data <= {13'h0000, mon1_control0};
        `RSS_OFS_MON2_CTL: rd_data <= {13'h0000, mon2_control0};
        `RSS_OFS_LEVEL: rd_data <= {10'h000, level2_select, level1_select};
        `RSS_OFS_WDT_CTL: rd_data <= {15'h0000, wdt_reset_ctl};
        `RSS_OFS_PROTECT: rd_data <= {14'h0000, protect_write_enable1, 1'b0};
        `RSS_OFS_SEQ: rd_data <= {9'h000, last_src, 3'h0, (state == ST_HOLD)};
        default: rd_data <= 16'h0000;
      endcase
    end else begin
      rd_data <= 16'h0000;
    end
  end

endmodule : rss_top

`default_nettype wire

// ==== verif/rss_far_end.sv ====
`default_nettype none
// ----
// far side: reset pin driver, supply detectors, watchdog event pulses
// ----
module rss_far_end (
  input wire logic sys_clk,
  output logic pin_n,
  output logic por_ok,
  output logic low1,
  output logic low2,
  output logic wdt_uf,
  output logic wdt_re
);
  timeunit 1ns;
  timeprecision 1ns;
  // idle: pin high, supply good
  initial begin
    pin_n = 1'b1;
    por_ok = 1'b1;
    low1 = 1'b0;
    low2 = 1'b0;
    wdt_uf = 1'b0;
    wdt_re = 1'b0;
  end
  // levels change just after an edge and stay
  task drive(input int which, input logic val);
    @(posedge sys_clk);
    case (which)
      0: pin_n <= val;
      1: low1 <= val;
      default: low2 <= val;
    endcase
  endtask : drive
  // watchdog events: one-cycle pulses
  task wdt_pulse(input logic refresh);
    @(posedge sys_clk);
    if (refresh) wdt_re <= 1'b1;
    else wdt_uf <= 1'b1;
    @(posedge sys_clk);
    wdt_re <= 1'b0;
    wdt_uf <= 1'b0;
  endtask : wdt_pulse
endmodule : rss_far_end
`default_nettype wire

// ==== verif/rss_top_assertions.sv ====
`include "rss_regs.svh"
`default_nettype none
module rss_top_chk import rss_pkg::*; #(
  parameter int POR_CYCLES = `RSS_POR_CYC
) (
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic ext_reset_pin_n,
  input wire logic vcc_above_por,
  input wire logic [31:0] option_word0,
  input wire logic wdt_underflow,
  input wire logic wdt_refresh_error,
  input wire rss_bus_req_type bus_req,
  input wire logic [15:0] rd_data,
  input wire logic cpu_reset_n,
  input wire logic [3:0] level1_select,
  input wire logic [1:0] level2_select
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rstn);
  // saturating counts since pin high, supply ok, internal event
  logic [16:0] pin_cnt, por_cnt, int_cnt;
  logic wdt_on, key_wr;
  assign wdt_on = !option_word0[1] && option_word0[12];
  assign key_wr = bus_req.wr && bus_req.addr == `RSS_OFS_SOFT_KEY && bus_req.wdata == `RSS_SOFT_KEY;
  // refused key writes restart int_cnt too: stricter
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      pin_cnt <= '0;
      por_cnt <= '0;
      int_cnt <= '1;
    end else begin
      pin_cnt <= !ext_reset_pin_n ? '0 : pin_cnt + {16'h0, ~&pin_cnt};
      por_cnt <= !vcc_above_por ? '0 : por_cnt + {16'h0, ~&por_cnt};
      int_cnt <= ((wdt_underflow || wdt_refresh_error) && wdt_on) || key_wr ? '0
        : int_cnt + {16'h0, ~&int_cnt};
    end
  end
  sequence s_key;
    bus_req.wr && bus_req.addr == `RSS_OFS_PROTECT && bus_req.wdata[1] ##2 key_wr;
  endsequence
  a_pin_holds: assert property (!ext_reset_pin_n [*5] |-> !cpu_reset_n)
    else $error("cpu runs while pin low");
  a_pin_wait: assert property ($rose(cpu_reset_n) |-> pin_cnt >= 1000)
    else $error("pin release too soon");
  a_por_holds: assert property (!vcc_above_por [*5] |-> !cpu_reset_n)
    else $error("cpu runs while supply low");
  a_por_time: assert property ($rose(cpu_reset_n) |-> por_cnt >= POR_CYCLES)
    else $error("power-on release too soon");
  a_int_time: assert property ($rose(cpu_reset_n) |-> int_cnt >= 499)
    else $error("internal reset too short");
  a_soft_key: assert property (s_key |=> ##1 !cpu_reset_n [*4])
    else $error("key write gave no reset");
  a_wdt_reset: assert property ((wdt_underflow || wdt_refresh_error) && wdt_on
    |=> ##1 !cpu_reset_n [*4]) else $error("no watchdog reset");
  a_key_zero: assert property (bus_req.rd && bus_req.addr == `RSS_OFS_SOFT_KEY
    |=> rd_data == 16'h0000) else $error("key reads nonzero");
  a_level_set: assert property (bus_req.wr && bus_req.addr == `RSS_OFS_LEVEL |=>
    level1_select == $past(bus_req.wdata[3:0]) && level2_select == $past(bus_req.wdata[5:4]))
    else $error("detect levels not taken");
endmodule : rss_top_chk
bind rss_top rss_top_chk #(.POR_CYCLES(POR_CYCLES)) i_chk (.sys_clk(sys_clk), .rstn(rstn),
  .ext_reset_pin_n(ext_reset_pin_n), .vcc_above_por(vcc_above_por),
  .option_word0(option_word0), .wdt_underflow(wdt_underflow),
  .wdt_refresh_error(wdt_refresh_error), .bus_req(bus_req), .rd_data(rd_data),
  .cpu_reset_n(cpu_reset_n), .level1_select(level1_select), .level2_select(level2_select));
`default_nettype wire

// ==== verif/rss_top_tb.sv ====
`include "rss_regs.svh"
`default_nettype none
module rss_top_tb import rss_pkg::*; ;
  timeunit 1ns;
  timeprecision 1ns;
  logic sys_clk = 1'b0;
  logic rstn = 1'b0;
  logic [31:0] option_word0 = 32'h0000_1000; // auto-start, reset on expiry
  rss_bus_req_type bus_req = '0;
  logic [15:0] rd_data;
  logic cpu_reset_n, pin_n, por_ok, low1, low2, uf, re;
  logic [3:0] level1_select;
  logic [1:0] level2_select;
  int failures = 0;
  int total_checks = 0;
  always #20 sys_clk = ~sys_clk;
  rss_far_end i_far (.sys_clk(sys_clk), .pin_n(pin_n), .por_ok(por_ok), .low1(low1),
    .low2(low2), .wdt_uf(uf), .wdt_re(re));
  // short power-on time
  rss_top #(.POR_CYCLES(20)) i_dut (.sys_clk(sys_clk), .rstn(rstn), .ext_reset_pin_n(pin_n),
    .vcc_above_por(por_ok), .vcc_below_level1(low1), .vcc_below_level2(low2),
    .option_word0(option_word0), .wdt_underflow(uf), .wdt_refresh_error(re),
    .bus_req(bus_req), .rd_data(rd_data), .cpu_reset_n(cpu_reset_n),
    .level1_select(level1_select), .level2_select(level2_select));
  task check(input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp) begin
      failures++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  task end_of_test;
    $display("checks=%0d failures=%0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : end_of_test
  // one-cycle strobes, then a gap cycle
  task wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge sys_clk);
    bus_req <= {a, d, 2'b10};
    @(posedge sys_clk);
    bus_req <= '0;
  endtask : wr
  task rd(input logic [7:0] a, input logic [15:0] exp);
    @(posedge sys_clk);
    bus_req <= {a, 16'h0000, 2'b01};
    @(posedge sys_clk);
    bus_req <= '0;
    #1 check(rd_data, exp);
  endtask : rd
  // held first, then released in bounded time
  task wait_rel;
    int n;
    n = 0;
    repeat (6) @(posedge sys_clk);
    check(cpu_reset_n, 16'h0000);
    while (cpu_reset_n !== 1'b1 && n < 6000) begin
      @(posedge sys_clk);
      n++;
    end
    if (n >= 6000) begin
      failures++;
      end_of_test();
    end
  endtask : wait_rel
  initial begin
    repeat (5) @(posedge sys_clk);
    rstn <= 1'b1;
    wait_rel();
    rd(`RSS_OFS_STATUS0, 16'h0001);
    rd(`RSS_OFS_STATUS1, 16'h0000);
    wr(`RSS_OFS_STATUS1, 16'h0000);
    rd(`RSS_OFS_STATUS1, 16'h0000);
    wr(`RSS_OFS_STATUS1, 16'h0001);
    rd(`RSS_OFS_STATUS1, 16'h0001);
    i_far.drive(0, 1'b0);
    repeat (10) @(posedge sys_clk);
    check(cpu_reset_n, 16'h0000);
    i_far.drive(0, 1'b1);
    wait_rel();
    rd(`RSS_OFS_STATUS0, 16'h0000);
    rd(`RSS_OFS_STATUS1, 16'h0001);
    // key: locked, wrong value, then right
    rd(`RSS_OFS_SOFT_KEY, 16'h0000);
    wr(`RSS_OFS_SOFT_KEY, `RSS_SOFT_KEY);
    wr(`RSS_OFS_PROTECT, 16'h0002);
    wr(`RSS_OFS_SOFT_KEY, 16'hA500);
    rd(`RSS_OFS_STATUS2, 16'h0000);
    wr(`RSS_OFS_PROTECT, 16'h0002);
    wr(`RSS_OFS_SOFT_KEY, `RSS_SOFT_KEY);
    wait_rel();
    rd(`RSS_OFS_STATUS2, 16'h0004);
    wr(`RSS_OFS_STATUS2, 16'h0004);
    wr(`RSS_OFS_STATUS2, 16'h0000);
    rd(`RSS_OFS_STATUS2, 16'h0004);
    wr(`RSS_OFS_STATUS2, 16'h0000);
    rd(`RSS_OFS_STATUS2, 16'h0000);
    rd(`RSS_OFS_STATUS1, 16'h0001);
    // watchdog: option, control, disabled
    i_far.wdt_pulse(1'b0);
    wait_rel();
    option_word0 <= 32'h0000_0002;
    wr(`RSS_OFS_WDT_CTL, 16'h0001);
    i_far.wdt_pulse(1'b1);
    wait_rel();
    rd(`RSS_OFS_STATUS2, 16'h0001);
    wr(`RSS_OFS_WDT_CTL, 16'h0000);
    i_far.wdt_pulse(1'b0);
    repeat (6) @(posedge sys_clk);
    check(cpu_reset_n, 16'h0001);
    // mon1 waits for recovery; mon2 releases while low
    wr(`RSS_OFS_MON1_CTL, 16'h0003);
    i_far.drive(1, 1'b1);
    repeat (3000) @(posedge sys_clk);
    i_far.drive(1, 1'b0);
    wait_rel();
    wr(`RSS_OFS_MON2_CTL, 16'h0007);
    i_far.drive(2, 1'b1);
    wait_rel();
    i_far.drive(2, 1'b0);
    rd(`RSS_OFS_STATUS0, 16'h000C);
    rd(`RSS_OFS_SEQ, 16'h0040);
    wr(`RSS_OFS_LEVEL, 16'h003A);
    #1 check({level2_select, level1_select}, 16'h003A);
    rd(8'h30, 16'h0000);
    end_of_test();
  end
endmodule : rss_top_tb
`default_nettype wire
